// ---- design/orb_pkg.sv ----
// Constants, types and register map of the overlay register bank.
// Assumes byte-addressed Wishbone: register index on adr[7:2].
package orb_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [5:0] PCTL_IDX = 6'h00;
    localparam logic [5:0] NIB_LAST_IDX = 6'h06;
    localparam logic [5:0] BR_BASE_IDX = 6'h10;
    localparam logic [5:0] BR_LAST_IDX = 6'h20;
    localparam logic [5:0] OVL_SEL_IDX = 6'h1a;
    localparam logic [5:0] DIAG_IDX = 6'h1e;
    localparam logic [5:0] OVL_BASE_IDX = 6'h30;
    localparam logic [5:0] OVL_LAST_IDX = 6'h39;
    localparam logic [5:0] DCHAN_PORT_IDX = 6'h3c;
    localparam logic [5:0] DUMP_PORT_IDX = 6'h3d;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PCTL_SOFT_RESET = 3;
    localparam int PCTL_PWRDN_EN = 2;
    localparam int PCTL_ABS_PWRDN = 1;
    localparam int PCTL_RET_NORMAL = 0;
    localparam int SEL_DUMP = 2;
    localparam int SEL_DCHAN = 1;
    localparam int SEL_INIT = 0;
    localparam int DIAG_SPLIT_RW = 6;
    localparam int OVL_TS_MODE = 6;
    localparam int OVL_IF_MODE = 7;
    localparam int OVL_ANALOG = 9;
    localparam int ASG_B1_EN = 7;
    localparam int ASG_B2_EN = 6;
    localparam int ASG_D_EN = 5;
    localparam int GCI_MODE_EN = 3;
    localparam int IF_LINK_RATE = 4;
    localparam int IF_LONG_FRAME = 3;
    localparam int IF_M4_TRINAL = 0;
    localparam int AN_OPEN_FB = 6;
    localparam int AN_LOOPBACK = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] PCTL_RST = 4'h0;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [7:0] DIAG_RST = 8'h00;
    localparam logic [7:0] OVL_RST = 8'h00;

    // ------------------------------------------------------------
    // Bit types per register, index 0 = first register of the group
    // ------------------------------------------------------------
    localparam logic [6:0][11:0] NIB_VALID = {12'hfff, 12'h007, 12'h00f, 12'h00f,
        12'h00f, 12'h00f, 12'h00f};
    localparam logic [6:0][11:0] NIB_RDONLY = {12'h000, 12'h000, 12'h000, 12'h00f,
        12'h000, 12'h00f, 12'h000};
    localparam logic [16:0][7:0] BYTE_VALID = {8'hc9, 8'hff, 8'h59, 8'hff, 8'hff,
        8'hff, 8'h07, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'hff, 8'hff};
    localparam logic [16:0][7:0] BYTE_RDONLY = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00};
    localparam logic [16:0][7:0] BYTE_SPLIT = {8'h00, 8'hff, 8'h00, 8'hff, 8'hff,
        8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ORB_IDLE = 2'b00,
        ORB_WAIT = 2'b01,
        ORB_ACK = 2'b10
    } orb_state_t;

    typedef enum logic [2:0] {
        ORB_REG_NONE = 3'b000,
        ORB_REG_NIB = 3'b001,
        ORB_REG_BYTE = 3'b010,
        ORB_REG_OVL = 3'b011,
        ORB_REG_DCHAN = 3'b100,
        ORB_REG_DUMP = 3'b101
    } orb_region_t;

endpackage

// ---- design/orb_ram.sv ----
// Backing store for the written values of nibble and byte registers.
// Assumes one write and one read per cycle; read data is registered.
module orb_ram (
    input wire logic clk,
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [11:0] wdata,
    input wire logic [5:0] raddr,
    output logic [11:0] rdata
);
    // No reset on the array: software must write before trusting readback
    logic [11:0] mem [0:63];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// ---- design/orb_port.sv ----
// Byte data port: holds a transmit byte with a strobe, captures a received byte.
// Assumes receive data and strobes come from logic on the same clock.
module orb_port (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic [7:0] tx_data,
    output logic tx_stb,
    output logic [7:0] rx_q
);
    typedef struct packed {
        logic [7:0] tx;
        logic stb;
        logic [7:0] rx;
    } orb_port_regs_t;

    orb_port_regs_t r_r;
    orb_port_regs_t r_nxt;

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.stb = wr;
        if (wr)
        begin
            r_nxt.tx = wdata;
        end
        if (rx_valid)
        begin
            r_nxt.rx = rx_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign tx_data = r_r.tx;
    assign tx_stb = r_r.stb;
    assign rx_q = r_r.rx;
endmodule

// ---- design/orb_regbank.sv ----
// Overlay register bank of a line transceiver, reached over classic Wishbone.
// Assumes status inputs and port data come from logic on clk.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
module orb_regbank (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [6:0][11:0] nib_status,
    input wire logic [16:0][7:0] byte_status,
    output logic soft_reset,
    output logic power_down_en,
    output logic abs_power_down,
    output logic return_to_normal,
    output logic [5:0][7:0] timeslot,
    output logic [2:0] asg_enable,
    output logic gci_mode,
    output logic link_long_frame,
    output logic link_rate,
    output logic m4_trinal,
    output logic open_feedback,
    output logic analog_loopback,
    output logic [9:0][7:0] ovl_ctrl,
    output logic [7:0] d_channel_tx,
    output logic d_channel_tx_stb,
    input wire logic d_channel_rx_valid,
    input wire logic [7:0] d_channel_rx,
    output logic d_channel_rd,
    output logic [7:0] dump_wdata,
    output logic dump_wr,
    input wire logic dump_load,
    input wire logic [7:0] dump_value,
    output logic dump_rd
);
    typedef struct packed {
        orb_pkg::orb_state_t st;
        logic ack;
        logic [31:0] dat;
        logic [3:0] pctl;
        logic [2:0] osel;
        logic [7:0] diag;
        logic [9:0][7:0] ovl;
        logic dchan_rd;
        logic dump_rd;
    } orb_regs_t;

    orb_regs_t r_r;
    orb_regs_t r_nxt;

    logic [5:0] idx;
    orb_pkg::orb_region_t region;
    logic [11:0] ram_q;
    logic ram_we;
    logic [11:0] ram_wdata;
    logic dchan_wr;
    logic dump_wr_req;
    logic [7:0] dchan_rx_q;
    logic [7:0] dump_q;
    logic [11:0] rd_val;
    logic [11:0] wr_merge;
    logic [4:0] bidx;
    logic [2:0] nidx;
    logic [3:0] oidx;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic orb_pkg::orb_region_t orb_decode(input logic [5:0] a,
        input logic [2:0] sel);
        orb_pkg::orb_region_t rg;
        rg = orb_pkg::ORB_REG_NONE;
        if (a <= orb_pkg::NIB_LAST_IDX)
        begin
            rg = orb_pkg::ORB_REG_NIB;
        end
        else if (a >= orb_pkg::BR_BASE_IDX && a <= orb_pkg::BR_LAST_IDX)
        begin
            rg = orb_pkg::ORB_REG_BYTE;
        end
        // Unselected overlay addresses fall through to unmapped
        else if (a >= orb_pkg::OVL_BASE_IDX && a <= orb_pkg::OVL_LAST_IDX
            && sel[orb_pkg::SEL_INIT])
        begin
            rg = orb_pkg::ORB_REG_OVL;
        end
        else if (a == orb_pkg::DCHAN_PORT_IDX && sel[orb_pkg::SEL_DCHAN])
        begin
            rg = orb_pkg::ORB_REG_DCHAN;
        end
        else if (a == orb_pkg::DUMP_PORT_IDX && sel[orb_pkg::SEL_DUMP])
        begin
            rg = orb_pkg::ORB_REG_DUMP;
        end
        return rg;
    endfunction

    assign idx = wb_adr_i[7:2];
    assign region = orb_decode(idx, r_r.osel);
    assign bidx = 5'(idx - orb_pkg::BR_BASE_IDX);
    assign nidx = idx[2:0];
    assign oidx = 4'(idx - orb_pkg::OVL_BASE_IDX);

    // ------------------------------------------------------------
    // Written-value store and data ports
    // ------------------------------------------------------------
    orb_ram u_ram (
        .clk(clk),
        .we(ram_we),
        .waddr(idx),
        .wdata(ram_wdata),
        .raddr(idx),
        .rdata(ram_q)
    );

    orb_port u_dchan (
        .clk(clk),
        .rstn(rstn),
        .wr(dchan_wr),
        .wdata(wb_dat_i[7:0]),
        .rx_valid(d_channel_rx_valid),
        .rx_data(d_channel_rx),
        .tx_data(d_channel_tx),
        .tx_stb(d_channel_tx_stb),
        .rx_q(dchan_rx_q)
    );

    orb_port u_dump (
        .clk(clk),
        .rstn(rstn),
        .wr(dump_wr_req),
        .wdata(wb_dat_i[7:0]),
        .rx_valid(dump_load),
        .rx_data(dump_value),
        .tx_data(dump_wdata),
        .tx_stb(dump_wr),
        .rx_q(dump_q)
    );

    // ------------------------------------------------------------
    // Read value and byte-lane merge
    // ------------------------------------------------------------
    always_comb
    begin
        logic [11:0] stat;
        logic [11:0] rdonly;
        logic [11:0] split;
        logic [11:0] valid;
        stat = '0;
        rdonly = '0;
        split = '0;
        valid = '0;
        rd_val = '0;
        wr_merge[11:8] = wb_sel_i[1] ? wb_dat_i[11:8] : ram_q[11:8];
        wr_merge[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : ram_q[7:0];
        unique case (region)
            orb_pkg::ORB_REG_NIB:
            begin
                stat = nib_status[nidx];
                rdonly = orb_pkg::NIB_RDONLY[nidx];
                valid = orb_pkg::NIB_VALID[nidx];
            end
            orb_pkg::ORB_REG_BYTE:
            begin
                stat = {4'h0, byte_status[bidx]};
                rdonly = {4'h0, orb_pkg::BYTE_RDONLY[bidx]};
                split = {4'h0, orb_pkg::BYTE_SPLIT[bidx]};
                valid = {4'h0, orb_pkg::BYTE_VALID[bidx]};
            end
            default:
            begin
            end
        endcase
        unique case (region)
            orb_pkg::ORB_REG_NIB, orb_pkg::ORB_REG_BYTE:
            begin
                rd_val = (ram_q & ~rdonly & ~split) | (stat & rdonly);
                if (r_r.diag[orb_pkg::DIAG_SPLIT_RW])
                begin
                    rd_val = rd_val | (ram_q & split);
                end
                else
                begin
                    rd_val = rd_val | (stat & split);
                end
                rd_val = rd_val & valid;
                if (idx == orb_pkg::PCTL_IDX)
                begin
                    // Hidden while in absolute power-down
                    rd_val = r_r.pctl[orb_pkg::PCTL_ABS_PWRDN] ? 12'h000
                        : {8'h00, r_r.pctl};
                end
                else if (idx == orb_pkg::OVL_SEL_IDX)
                begin
                    rd_val = {9'h000, r_r.osel};
                end
                else if (idx == orb_pkg::DIAG_IDX)
                begin
                    rd_val = {4'h0, r_r.diag};
                end
            end
            orb_pkg::ORB_REG_OVL: rd_val = {4'h0, r_r.ovl[oidx]};
            orb_pkg::ORB_REG_DCHAN: rd_val = {4'h0, dchan_rx_q};
            orb_pkg::ORB_REG_DUMP: rd_val = {4'h0, dump_q};
            default: rd_val = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Bus sequencing and register writes
    // ------------------------------------------------------------
    always_comb
    begin
        logic wr_now;
        wr_now = (r_r.st == orb_pkg::ORB_WAIT) && wb_cyc_i && wb_stb_i && wb_we_i;
        r_nxt = r_r;
        r_nxt.dchan_rd = 1'b0;
        r_nxt.dump_rd = 1'b0;
        ram_we = 1'b0;
        ram_wdata = wr_merge;
        dchan_wr = 1'b0;
        dump_wr_req = 1'b0;
        unique case (r_r.st)
            orb_pkg::ORB_IDLE:
            begin
                r_nxt.ack = 1'b0;
                if (wb_cyc_i && wb_stb_i)
                begin
                    r_nxt.st = orb_pkg::ORB_WAIT;
                end
            end
            orb_pkg::ORB_WAIT:
            begin
                // One cycle for the store's registered read
                r_nxt.st = orb_pkg::ORB_ACK;
                r_nxt.ack = 1'b1;
                r_nxt.dat = {20'h00000, rd_val};
                if (!wb_we_i)
                begin
                    r_nxt.dchan_rd = (region == orb_pkg::ORB_REG_DCHAN);
                    r_nxt.dump_rd = (region == orb_pkg::ORB_REG_DUMP);
                end
            end
            orb_pkg::ORB_ACK:
            begin
                r_nxt.st = orb_pkg::ORB_IDLE;
                r_nxt.ack = 1'b0;
            end
            default:
            begin
                r_nxt.st = orb_pkg::ORB_IDLE;
                r_nxt.ack = 1'b0;
            end
        endcase
        if (wr_now && wb_sel_i[0])
        begin
            unique case (region)
                orb_pkg::ORB_REG_NIB, orb_pkg::ORB_REG_BYTE:
                begin
                    // Store every written value; read-only bits mask it on read
                    ram_we = 1'b1;
                    if (idx == orb_pkg::PCTL_IDX)
                    begin
                        r_nxt.pctl = wb_dat_i[3:0];
                    end
                    else if (idx == orb_pkg::OVL_SEL_IDX)
                    begin
                        r_nxt.osel = wb_dat_i[2:0];
                    end
                    else if (idx == orb_pkg::DIAG_IDX)
                    begin
                        r_nxt.diag = wb_dat_i[7:0] & orb_pkg::BYTE_VALID[bidx];
                    end
                end
                orb_pkg::ORB_REG_OVL: r_nxt.ovl[oidx] = wb_dat_i[7:0];
                orb_pkg::ORB_REG_DCHAN: dchan_wr = 1'b1;
                orb_pkg::ORB_REG_DUMP: dump_wr_req = 1'b1;
                default:
                begin
                end
            endcase
        end
        else if (wr_now && wb_sel_i[1] && region == orb_pkg::ORB_REG_NIB)
        begin
            ram_we = 1'b1;
        end
    end

    // Only the hardware reset pin clears these; soft reset is just an output
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            r_r <= '{st: orb_pkg::ORB_IDLE, ack: 1'b0, dat: 32'h00000000,
                pctl: orb_pkg::PCTL_RST, osel: orb_pkg::SEL_RST,
                diag: orb_pkg::DIAG_RST, ovl: {10{orb_pkg::OVL_RST}},
                dchan_rd: 1'b0, dump_rd: 1'b0};
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = r_r.ack;
    assign wb_dat_o = r_r.dat;
    assign soft_reset = r_r.pctl[orb_pkg::PCTL_SOFT_RESET];
    assign power_down_en = r_r.pctl[orb_pkg::PCTL_PWRDN_EN];
    assign abs_power_down = r_r.pctl[orb_pkg::PCTL_ABS_PWRDN];
    assign return_to_normal = r_r.pctl[orb_pkg::PCTL_RET_NORMAL];
    assign timeslot = r_r.ovl[5:0];
    assign asg_enable = {r_r.ovl[orb_pkg::OVL_TS_MODE][orb_pkg::ASG_B1_EN],
        r_r.ovl[orb_pkg::OVL_TS_MODE][orb_pkg::ASG_B2_EN],
        r_r.ovl[orb_pkg::OVL_TS_MODE][orb_pkg::ASG_D_EN]};
    assign gci_mode = r_r.ovl[orb_pkg::OVL_TS_MODE][orb_pkg::GCI_MODE_EN];
    assign link_long_frame = r_r.ovl[orb_pkg::OVL_IF_MODE][orb_pkg::IF_LONG_FRAME];
    assign link_rate = r_r.ovl[orb_pkg::OVL_IF_MODE][orb_pkg::IF_LINK_RATE];
    assign m4_trinal = r_r.ovl[orb_pkg::OVL_IF_MODE][orb_pkg::IF_M4_TRINAL];
    assign open_feedback = r_r.ovl[orb_pkg::OVL_ANALOG][orb_pkg::AN_OPEN_FB];
    assign analog_loopback = r_r.ovl[orb_pkg::OVL_ANALOG][orb_pkg::AN_LOOPBACK];
    assign ovl_ctrl = r_r.ovl;
    assign d_channel_rd = r_r.dchan_rd;
    assign dump_rd = r_r.dump_rd;
endmodule

// ---- sim/orb_regbank_chk.sv ----
// Concurrent checks on the ports of the overlay register bank.
// Assumes one clock domain with a synchronous active-low reset.
module orb_regbank_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic soft_reset,
    input wire logic abs_power_down,
    input wire logic [5:0][7:0] timeslot,
    input wire logic [2:0] asg_enable,
    input wire logic gci_mode,
    input wire logic link_long_frame,
    input wire logic link_rate,
    input wire logic m4_trinal,
    input wire logic open_feedback,
    input wire logic analog_loopback,
    input wire logic [9:0][7:0] ovl_ctrl,
    input wire logic [7:0] d_channel_tx,
    input wire logic d_channel_tx_stb,
    input wire logic d_channel_rd,
    input wire logic [7:0] dump_wdata,
    input wire logic dump_wr,
    input wire logic dump_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [5:0] idx = wb_adr_i[7:2];
    wire logic wr_ack = wb_ack_o && wb_we_i;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Bus timing and register side effects
    // ------------------------------------------------------------
    a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |->
        !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack not two cycles after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ctrl_hold: assert property ($changed({soft_reset, abs_power_down}) |->
        wr_ack && idx == orb_pkg::PCTL_IDX) else $error("power control moved without write");
    a_pwrdn_read: assert property (wb_ack_o && !wb_we_i && idx == orb_pkg::PCTL_IDX
        && abs_power_down |-> wb_dat_o == 32'h0) else $error("power control readable");
    a_ts_write: assert property ($changed(timeslot) |-> wr_ack
        && idx >= 6'h30 && idx <= 6'h35) else $error("timeslot moved without write");
    a_ts_mirror: assert property (timeslot == ovl_ctrl[5:0])
        else $error("timeslot outputs differ from overlay bytes");
    a_asg_bits: assert property (asg_enable == ovl_ctrl[6][7:5]
        && gci_mode == ovl_ctrl[6][3]) else $error("assigner enables misplaced");
    a_if_bits: assert property ({link_rate, link_long_frame, m4_trinal} ==
        {ovl_ctrl[7][4], ovl_ctrl[7][3], ovl_ctrl[7][0]}) else $error("interface mode misplaced");
    a_analog_bits: assert property ({open_feedback, analog_loopback} == ovl_ctrl[9][6:5])
        else $error("analog controls misplaced");
    a_dchan_tx: assert property (d_channel_tx_stb |-> wr_ack && idx == 6'h3c
        && d_channel_tx == wb_dat_i[7:0]) else $error("transmit strobe without port write");
    a_dchan_rd: assert property (d_channel_rd |-> wb_ack_o && !wb_we_i && idx == 6'h3c)
        else $error("receive pulse without port read");
    a_dump_wr: assert property (dump_wr |-> wr_ack && idx == 6'h3d
        && dump_wdata == wb_dat_i[7:0]) else $error("dump write without port write");
    a_dump_rd: assert property (dump_rd |-> wb_ack_o && !wb_we_i && idx == 6'h3d)
        else $error("dump read pulse without port read");
endmodule

// ---- sim/orb_far_model.sv ----
// Model of the internal logic behind the bank: status, received bytes, dump loads.
// Assumes the bench calls push from a process synchronised to clk.
module orb_far_model (
    input wire logic clk,
    output logic [6:0][11:0] nib_status,
    output logic [16:0][7:0] byte_status,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic load,
    output logic [7:0] load_value
);
    timeunit 1ns;
    timeprecision 1ps;

    // Fixed patterns, unlike any written value, so a leak shows
    initial
    begin
        nib_status = {7{12'h5a5}};
        byte_status = {17{8'hc6}};
        rx_valid = 1'b0;
        rx_data = 8'h00;
        load = 1'b0;
        load_value = 8'h00;
    end

    // Data lines go to the inverse once released, never hold the old byte
    task automatic push(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        load <= 1'b1;
        load_value <= ~b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        load <= 1'b0;
        load_value <= b;
    endtask
endmodule

// ---- sim/orb_regbank_bench.sv ----
// Self-checking bench of the overlay register bank over classic Wishbone.
// Assumes the checker and far-side model are compiled before this file.
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module orb_regbank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [6:0][11:0] nib_st;
    logic [16:0][7:0] byte_st;
    logic rx_valid, dump_load, soft_reset, abs_pd, gci_mode, long_fr, rate, m4, open_fb, an_lb;
    logic [7:0] rx_data, dump_value, d_tx, dump_wdata;
    logic [5:0][7:0] timeslot;
    logic [2:0] asg_enable;
    logic pd_en, ret_norm;
    logic [7:0] ov [10] = '{8'h01, 8'h12, 8'h23, 8'h34, 8'h45, 8'h56, 8'ha8, 8'h19, 8'h38, 8'h60};
    int err_count = 0;
    int checks = 0;

    always #20 clk = ~clk;

    orb_far_model i_far (.clk(clk), .nib_status(nib_st), .byte_status(byte_st),
        .rx_valid(rx_valid), .rx_data(rx_data), .load(dump_load), .load_value(dump_value));

    orb_regbank i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .nib_status(nib_st), .byte_status(byte_st),
        .soft_reset(soft_reset), .power_down_en(pd_en), .abs_power_down(abs_pd),
        .return_to_normal(ret_norm), .timeslot(timeslot), .asg_enable(asg_enable),
        .gci_mode(gci_mode), .link_long_frame(long_fr), .link_rate(rate), .m4_trinal(m4),
        .open_feedback(open_fb), .analog_loopback(an_lb), .ovl_ctrl(), .d_channel_tx(d_tx),
        .d_channel_tx_stb(), .d_channel_rx_valid(rx_valid), .d_channel_rx(rx_data),
        .d_channel_rd(), .dump_wdata(dump_wdata), .dump_wr(), .dump_load(dump_load),
        .dump_value(dump_value), .dump_rd());

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic acc(input logic w, input logic [5:0] idx, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= d;
        sel <= 4'h3;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        `CHK("ack", 1'b1, wb_ack_o)
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, idx, d, q);
    endtask

    task automatic chk_rd(input logic [5:0] idx, input logic [31:0] e, input string nm);
        logic [31:0] q;
        acc(1'b0, idx, 32'h0, q);
        `CHK(nm, e, q)
    endtask

    task automatic final_report;
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk_rd(6'h00, 32'h0, "reset_power_control");
        wr(6'h10, 32'ha5);
        chk_rd(6'h10, 32'ha5, "byte0");
        wr(6'h06, 32'habc);
        chk_rd(6'h06, 32'habc, "twelve_bit");
        wr(6'h02, 32'h9);
        chk_rd(6'h02, 32'h9, "nibble2");
        wr(6'h11, 32'hff);
        chk_rd(6'h11, 32'hc6, "byte1_status");
        wr(6'h01, 32'ha);
        chk_rd(6'h01, 32'h5, "nibble1_status");
        wr(6'h18, 32'h3c);
        chk_rd(6'h18, 32'hc6, "split_status");
        wr(6'h1e, 32'h40);
        chk_rd(6'h18, 32'h3c, "split_written");
        chk_rd(6'h11, 32'hc6, "rdonly_under_diag");
        chk_rd(6'h10, 32'ha5, "rw_under_diag");
        wr(6'h1e, 32'h0);
        wr(6'h1a, 32'h5);
        wr(6'h00, 32'h8);
        `CHK("soft_reset", 1'b1, soft_reset)
        chk_rd(6'h00, 32'h8, "ctrl_in_soft_reset");
        chk_rd(6'h1a, 32'h5, "select_in_soft_reset");
        wr(6'h00, 32'h6);
        `CHK("abs_power_down", 1'b1, abs_pd)
        chk_rd(6'h00, 32'h0, "ctrl_hidden");
        wr(6'h00, 32'h5);
        `CHK("power_control", 4'h5, {soft_reset, pd_en, abs_pd, ret_norm})
        chk_rd(6'h00, 32'h5, "ctrl_visible");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk_rd(6'h00, 32'h0, "ctrl_after_reset");
        chk_rd(6'h1a, 32'h0, "select_after_reset");
        wr(6'h30, 32'h77);
        chk_rd(6'h30, 32'h0, "unselected_overlay");
        `CHK("timeslot0", 8'h00, timeslot[0])
        wr(6'h1a, 32'h1);
        for (int i = 0; i < 10; i++)
            wr(6'h30 + 6'(i), {24'h0, ov[i]});
        for (int i = 0; i < 10; i++)
            chk_rd(6'h30 + 6'(i), {24'h0, ov[i]}, "overlay");
        for (int i = 0; i < 6; i++)
            `CHK("timeslot", ov[i], timeslot[i])
        `CHK("asg_gci", 4'hb, {asg_enable, gci_mode})
        `CHK("if_mode", 3'h7, {rate, long_fr, m4})
        `CHK("analog", 2'h3, {open_fb, an_lb})
        chk_rd(6'h3c, 32'h0, "dchan_unselected");
        wr(6'h1a, 32'h2);
        chk_rd(6'h30, 32'h0, "init_unselected");
        wr(6'h3c, 32'hc3);
        `CHK("d_channel_tx", 8'hc3, d_tx)
        i_far.push(8'h96);
        chk_rd(6'h3c, 32'h96, "d_channel_rx");
        wr(6'h1a, 32'h4);
        wr(6'h3d, 32'h7e);
        `CHK("dump_wdata", 8'h7e, dump_wdata)
        chk_rd(6'h3d, 32'h69, "dump_read");
        chk_rd(6'h3f, 32'h0, "unmapped");
        final_report;
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule

bind orb_regbank orb_regbank_chk i_chk (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .soft_reset(soft_reset),
    .abs_power_down(abs_power_down), .timeslot(timeslot), .asg_enable(asg_enable),
    .gci_mode(gci_mode), .link_long_frame(link_long_frame), .link_rate(link_rate),
    .m4_trinal(m4_trinal), .open_feedback(open_feedback), .analog_loopback(analog_loopback),
    .ovl_ctrl(ovl_ctrl), .d_channel_tx(d_channel_tx), .d_channel_tx_stb(d_channel_tx_stb),
    .d_channel_rd(d_channel_rd), .dump_wdata(dump_wdata), .dump_wr(dump_wr),
    .dump_rd(dump_rd));
